// ===== pss_pkg.sv
package pss_pkg;
  // main clock figures
  localparam int CLK_PERIOD_NS = 100;
  // debounce qualification time
  localparam int DEBOUNCE_MS = 32;
  // debounce time in clock cycles
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_MS * 1000000) / CLK_PERIOD_NS;
  // power-up routine length in cycles
  localparam int POWERUP_CYCLES = 16;
  // reset values of the power controls
  localparam logic RST_PWR_ON = 1'b0;
  // switch level that counts as a press or slider on
  localparam logic SW_ACTIVE = 1'b0;
  // strap level that selects push-button
  localparam logic STRAP_PUSH = 1'b1;
  // controller states
  typedef enum logic [1:0] {
    PSS_SLEEP,
    PSS_POWERUP,
    PSS_NORMAL
  } pss_state_e;
endpackage

// ===== pss_if.sv
`timescale 1ns/1ps
// carries the debounced press between filter and controller
interface pss_if;
  logic press; // one-cycle pulse per qualified press
  logic clear; // restart the filter
  modport filt (output press, input clear);
  modport ctrl (input press, output clear);
endinterface

// ===== pss_debounce.sv
`timescale 1ns/1ps
// push-button press qualifier
module pss_debounce
  import pss_pkg::*;
#(
  parameter int CYCLES = DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_level,
  pss_if.filt bus
);
  initial begin
    if (CYCLES < 2) begin
      $error("debounce count too small");
    end
  end
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt; // cycles the press has held
  logic fired; // press already reported
  logic [CW-1:0] next_cnt;
  logic next_fired;
  logic next_press;
  logic press_q;
  // count a held press, restart on release
  always_comb begin
    next_cnt = cnt;
    next_fired = fired;
    next_press = 1'b0;
    if (bus.clear || sw_level != SW_ACTIVE) begin
      next_cnt = '0;
      next_fired = 1'b0;
    end else if (!fired) begin
      if (cnt == CW'(CYCLES - 1)) begin
        next_press = 1'b1;
        next_fired = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end
  // register filter state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      fired <= 1'b0;
      press_q <= 1'b0;
    end else begin
      cnt <= next_cnt;
      fired <= next_fired;
      press_q <= next_press;
    end
  end
  assign bus.press = press_q;
  // press needs the full hold time
  a_press_after_hold: assert property (@(posedge clk) disable iff (rst)
    $rose(press_q) |-> $past(cnt) == CW'(CYCLES - 1))
    else $error("press without full hold");
endmodule

// ===== pss_ctrl.sv
`timescale 1ns/1ps
// How it works
// - strap low slider, high push-button
// - 32 ms debounced press toggles power
// - same press time for on and off
// - slider low turns on, starts power-up
// - slider level directly sets power state
// - sleep keeps supervisor/charger, regulator boost off
// - after power-up enter normal state
// - processor hold falling edge powers down, once hold was high during power-up
module pss_ctrl
  import pss_pkg::*;
#(
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
  parameter int UP_CYCLES = POWERUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic switch_in,
  input wire logic switch_type_strap,
  input wire logic hold_in,
  output logic regulator_enable,
  output logic boost_enable,
  output logic supervisor_enable,
  output logic charger_enable,
  output logic powered,
  output logic powerup_active
);
  // refuse a power-up length the timer cannot count
  initial begin
    if (UP_CYCLES < 1) begin
      $error("power-up length too small");
    end
  end
  // width of the power-up timer
  localparam int UW = $clog2(UP_CYCLES + 1);
  logic sw_m; // switch pin, first stage
  logic sw_s; // switch pin, settled
  logic st_m; // strap, first stage
  logic st_s; // strap, settled
  logic hd_m; // hold line, first stage
  logic hd_s; // hold line, settled
  // input synchronisers, first stage read only by second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // switch idles released, strap and hold low
      sw_m <= 1'b1;
      sw_s <= 1'b1;
      st_m <= 1'b0;
      st_s <= 1'b0;
      hd_m <= 1'b0;
      hd_s <= 1'b0;
    end else begin
      sw_m <= switch_in;
      sw_s <= sw_m;
      st_m <= switch_type_strap;
      st_s <= st_m;
      hd_m <= hold_in;
      hd_s <= hd_m;
    end
  end
  // link to the press filter
  pss_if dbi();
  // shared filter gives one on/off time
  pss_debounce #(.CYCLES(DEB_CYCLES)) u_deb (
    .clk(clk),
    .rst(rst),
    .sw_level(sw_s),
    .bus(dbi)
  );
  pss_state_e state; // power state
  pss_state_e next_state; // power state to come
  logic push_mode; // strap caught at wake
  logic next_push_mode; // strap as seen in sleep
  logic [UW-1:0] up_cnt; // power-up timer
  logic [UW-1:0] next_up_cnt; // power-up timer to come
  logic hold_q; // delayed hold for edge
  logic next_hold_q; // settled hold level
  logic hold_armed; // hold seen high during power-up
  logic next_hold_armed; // arming to come
  logic hold_fall; // hold dropped this cycle
  // falling edge of the settled hold line
  assign hold_fall = hold_q && !hd_s;
  // next state of the sequencer
  always_comb begin
    next_state = state;
    next_push_mode = push_mode;
    next_up_cnt = up_cnt;
    next_hold_q = hd_s;
    next_hold_armed = hold_armed;
    dbi.clear = 1'b0;
    case (state)
      // asleep: catch strap, wait for a wake request
      PSS_SLEEP: begin
        next_hold_armed = 1'b0;
        next_push_mode = (st_s == STRAP_PUSH);
        if (st_s == STRAP_PUSH) begin
          if (dbi.press) begin
            next_state = PSS_POWERUP;
            next_up_cnt = '0;
          end
        end else if (sw_s == SW_ACTIVE) begin
          next_state = PSS_POWERUP;
          next_up_cnt = '0;
        end
      end
      // waking: count out the power-up routine
      PSS_POWERUP: begin
        if (hd_s) begin
          next_hold_armed = 1'b1;
        end
        if (!push_mode && sw_s != SW_ACTIVE) begin
          next_state = PSS_SLEEP;
        end else if (up_cnt == UW'(UP_CYCLES - 1)) begin
          next_state = PSS_NORMAL;
        end else begin
          next_up_cnt = up_cnt + 1'b1;
        end
      end
      // running: watch for an off request
      PSS_NORMAL: begin
        if (hold_armed && hold_fall) begin
          next_state = PSS_SLEEP;
          dbi.clear = 1'b1;
        end else if (push_mode && dbi.press) begin
          next_state = PSS_SLEEP;
        end else if (!push_mode && sw_s != SW_ACTIVE) begin
          next_state = PSS_SLEEP;
        end
      end
      // unused code falls back to sleep
      default: begin
        next_state = PSS_SLEEP;
      end
    endcase
  end
  // register sequencer state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // reset: asleep, timer cleared
      state <= PSS_SLEEP;
      push_mode <= 1'b0;
      up_cnt <= '0;
      hold_q <= 1'b0;
      hold_armed <= 1'b0;
    end else begin
      state <= next_state;
      push_mode <= next_push_mode;
      up_cnt <= next_up_cnt;
      hold_q <= next_hold_q;
      hold_armed <= next_hold_armed;
    end
  end
  // supply enables, registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // reset: every switched supply off
      regulator_enable <= RST_PWR_ON;
      boost_enable <= RST_PWR_ON;
      powered <= RST_PWR_ON;
      powerup_active <= 1'b0;
    end else begin
      regulator_enable <= (next_state != PSS_SLEEP);
      boost_enable <= (next_state == PSS_NORMAL);
      powered <= (next_state != PSS_SLEEP);
      powerup_active <= (next_state == PSS_POWERUP);
    end
  end
  // always-on domains stay alive in sleep
  assign supervisor_enable = 1'b1;
  assign charger_enable = 1'b1;
  // checks on the sequencer and its outputs
  // supplies stay off while asleep
  a_sleep_supplies_off: assert property (@(posedge clk) disable iff (rst)
    state == PSS_SLEEP && $past(state) == PSS_SLEEP |-> !regulator_enable && !boost_enable)
    else $error("supply on in sleep");
  // slider pulled low leaves sleep
  a_slider_wakes: assert property (@(posedge clk) disable iff (rst)
    state == PSS_SLEEP && !st_s && !sw_s |=> state == PSS_POWERUP && regulator_enable)
    else $error("slider did not wake");
  // slider released powers off
  a_slider_off: assert property (@(posedge clk) disable iff (rst)
    state != PSS_SLEEP && !push_mode && sw_s |=> state == PSS_SLEEP)
    else $error("slider off ignored");
  // slider released keeps it asleep
  a_slider_stays_off: assert property (@(posedge clk) disable iff (rst)
    state == PSS_SLEEP && st_s != STRAP_PUSH && sw_s != SW_ACTIVE |=> state == PSS_SLEEP)
    else $error("slider off woke up");
  // qualified press wakes
  a_push_toggle_on: assert property (@(posedge clk) disable iff (rst)
    state == PSS_SLEEP && st_s && dbi.press |=> state == PSS_POWERUP)
    else $error("press did not power on");
  // no press, no wake in push mode
  a_push_needs_press: assert property (@(posedge clk) disable iff (rst)
    state == PSS_SLEEP && st_s == STRAP_PUSH && !dbi.press |=> state == PSS_SLEEP)
    else $error("woke without press");
  // same press puts it to sleep
  a_push_toggle_off: assert property (@(posedge clk) disable iff (rst)
    state == PSS_NORMAL && push_mode && dbi.press |=> state == PSS_SLEEP)
    else $error("press did not power off");
  // routine ends in normal
  a_powerup_len: assert property (@(posedge clk) disable iff (rst)
    state == PSS_POWERUP && up_cnt == UW'(UP_CYCLES - 1) && (push_mode || !sw_s)
    |=> state == PSS_NORMAL && boost_enable)
    else $error("normal not entered");
  // regulator only during power-up
  a_powerup_supplies: assert property (@(posedge clk) disable iff (rst)
    state == PSS_POWERUP |-> regulator_enable && powered && powerup_active && !boost_enable)
    else $error("wrong supplies in power-up");
  // both converters on when running
  a_normal_supplies: assert property (@(posedge clk) disable iff (rst)
    state == PSS_NORMAL |-> regulator_enable && boost_enable && powered && !powerup_active)
    else $error("wrong supplies in normal");
  // armed hold fall powers down
  a_hold_fall_off: assert property (@(posedge clk) disable iff (rst)
    state == PSS_NORMAL && hold_armed && hold_fall |=> state == PSS_SLEEP)
    else $error("hold fall ignored");
  // strap latched while asleep
  a_strap_mode: assert property (@(posedge clk) disable iff (rst)
    state == PSS_SLEEP |=> push_mode == $past(st_s))
    else $error("strap not caught");
endmodule

// ===== pss_user_model.sv
`timescale 1ns/1ps
// user switch and processor hold line on the far side of the controller
module pss_user_model (
  input wire logic clk,
  input wire logic press_req,
  input wire logic hold_req,
  output logic switch_in,
  output logic hold_in
);
  // pin idles high through the pull-up to the system rail
  initial switch_in = 1'b1;
  initial hold_in = 1'b0;
  // contact grounds the pin while pressed, processor drives hold level
  always @(posedge clk) begin
    switch_in <= press_req ? 1'b0 : 1'b1;
    hold_in <= hold_req;
  end
endmodule

// ===== power_switch_state_control_bench.sv
`timescale 1ns/1ps
module power_switch_state_control_bench;
  import pss_pkg::*;
  localparam int DEB = 20; // shortened debounce count
  localparam int UP = 16; // power-up length
  logic clk = 1'b0;
  logic rst;
  logic strap;
  logic press_req;
  logic hold_req;
  logic switch_in, hold_in, reg_en, bst_en, sup_en, chg_en, powered, pu_act;
  logic last_pwr = 1'b0; // last power level seen by the watcher
  logic exp_q[$]; // expected power levels in order
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'hdb85c0af;
  int n;
  always #50 clk = ~clk;
  pss_user_model u_user (.clk(clk), .press_req(press_req), .hold_req(hold_req),
    .switch_in(switch_in), .hold_in(hold_in));
  pss_ctrl #(.DEB_CYCLES(DEB), .UP_CYCLES(UP)) u_dut (.clk(clk), .rst(rst),
    .switch_in(switch_in), .switch_type_strap(strap), .hold_in(hold_in),
    .regulator_enable(reg_en), .boost_enable(bst_en), .supervisor_enable(sup_en),
    .charger_enable(chg_en), .powered(powered), .powerup_active(pu_act));
  // compare one value, report at once
  task automatic check(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hold the button n cycles, then release and let things settle
  task automatic press(input int cyc);
    press_req <= 1'b1;
    repeat (cyc) @(posedge clk);
    press_req <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  // watcher: every power change takes the oldest note, plus timeout
  always @(posedge clk) begin
    cycles++;
    if (cycles > 6000) begin
      miscompares++;
      give_verdict();
    end else if (!rst && powered !== last_pwr) begin
      last_pwr <= powered;
      if (exp_q.size() == 0) begin
        check(powered, last_pwr, "power changed unexpectedly");
      end else begin
        check(powered, exp_q.pop_front(), "wrong power level");
      end
    end
  end
  // main sequence
  initial begin
    rst <= 1'b1;
    strap <= 1'b0;
    press_req <= 1'b0;
    hold_req <= 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // slider mode: pin low powers up, high powers off
    exp_q.push_back(1'b1);
    press_req <= 1'b1;
    repeat (8) @(posedge clk);
    check(pu_act, 1'b1, "power-up not started");
    check(bst_en, 1'b0, "boost on in power-up");
    repeat (UP + 4) @(posedge clk);
    check(bst_en, 1'b1, "normal state not reached");
    check(pu_act, 1'b0, "power-up stuck");
    check(reg_en, 1'b1, "regulator off while slider on");
    exp_q.push_back(1'b0);
    press_req <= 1'b0;
    repeat (8) @(posedge clk);
    check(reg_en, 1'b0, "regulator on while slider off");
    check(bst_en, 1'b0, "boost on in sleep");
    check(sup_en & chg_en, 1'b1, "supervisor or charger off");
    // push-button mode, strap taken in sleep
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      n = 1 + int'($unsigned($random(seed)) % (DEB - 2));
      press(n);
    end
    // a bounce restarts the count
    press_req <= 1'b1;
    repeat (DEB - 3) @(posedge clk);
    press_req <= 1'b0;
    @(posedge clk);
    press(DEB - 3);
    check(powered, 1'b0, "bounced press toggled power");
    exp_q.push_back(1'b1);
    press(DEB + 4);
    check(powered, 1'b1, "press did not power on");
    exp_q.push_back(1'b0);
    press(DEB + 4);
    check(powered, 1'b0, "same press did not power off");
    // processor hold high in power-up, then its fall powers down
    hold_req <= 1'b1;
    exp_q.push_back(1'b1);
    press(DEB + 4);
    exp_q.push_back(1'b0);
    hold_req <= 1'b0;
    repeat (8) @(posedge clk);
    check(powered, 1'b0, "hold fall did not power down");
    check(logic'(exp_q.size() == 0), 1'b1, "expected change missing");
    give_verdict();
  end
endmodule
